// file: core/bpsw_pkg.sv
package bpsw_pkg;
  // Register byte offsets on the Avalon slave
  localparam logic [4:0] REG_OSC = 5'h00;
  localparam logic [4:0] REG_BG = 5'h04;
  localparam logic [4:0] REG_TMR = 5'h08;
  localparam logic [4:0] REG_RAM = 5'h0c;
  localparam logic [4:0] REG_STAT = 5'h10;
  localparam logic [4:0] REG_IRQ_EN = 5'h14;
  localparam logic [4:0] REG_WAKE_EN = 5'h18;
  localparam logic [4:0] REG_IW_LOCK = 5'h1c;
  // Oscillator control fields
  localparam int OSC_EN_BIT = 0;
  localparam int OSC_GATE_BIT = 1;
  localparam int OSC_LOCK_BIT = 2;
  localparam int OSC_RUN_BIT = 3;
  // Bandgap control fields
  localparam int BG_EN_BIT = 0;
  localparam int BG_RFR_EN_BIT = 1;
  localparam int BG_RFR_SEL_LSB = 2;
  localparam int BG_STATE_BIT = 4;
  // Timer control fields
  localparam int TMR_EN_LSB = 0;
  localparam int TMR0_SEL_LSB = 2;
  localparam int TMR1_SEL_LSB = 5;
  // RAM supply control fields
  localparam int RAM_REG_EN_BIT = 0;
  localparam int RAM_BATT_BIT = 1;
  localparam int RAM_RETAIN_BIT = 2;
  localparam int RAM_ISO_BIT = 3;
  localparam int RAM_LOCK_BIT = 4;
  // Status flag positions, also used by both enable registers
  localparam int NUM_FLAGS = 5;
  localparam int FLG_POR = 0;
  localparam int FLG_WAKE = 1;
  localparam int FLG_TMR0 = 2;
  localparam int FLG_TMR1 = 3;
  localparam int FLG_RDY = 4;
  localparam int ALL_EN_BIT = 5;
  localparam logic [3:0] FLAG_RESET = 4'h1;
  // Timing: system clock and slow oscillator period
  localparam int CLK_PERIOD_NS = 25;
  localparam int OSC_PERIOD_NS = 62500;
  localparam int OSC_DIV_CYC = OSC_PERIOD_NS / CLK_PERIOD_NS;
  localparam int REG_READY_TICKS = 16;
  // Refresh intervals in ns, then in oscillator ticks
  localparam int RFR0_NS = 7812500;
  localparam int RFR1_NS = 15625000;
  localparam int RFR2_NS = 31250000;
  localparam int RFR3_NS = 62500000;
  // Timer timeouts in ns
  localparam int TMO0_NS = 1000000000;
  localparam int TMO1_NS = 500000000;
  localparam int TMO2_NS = 250000000;
  localparam int TMO3_NS = 125000000;
  localparam int TMO4_NS = 62500000;
  localparam int TMO5_NS = 31250000;
  localparam int TICK_W = 14;

  function automatic logic [TICK_W-1:0] ticks(input int t_ns);
    ticks = TICK_W'(t_ns / OSC_PERIOD_NS);
  endfunction : ticks

  function automatic logic [TICK_W-1:0] refresh_ticks(input logic [1:0] sel);
    unique case (sel)
      2'h0: refresh_ticks = ticks(RFR0_NS);
      2'h1: refresh_ticks = ticks(RFR1_NS);
      2'h2: refresh_ticks = ticks(RFR2_NS);
      2'h3: refresh_ticks = ticks(RFR3_NS);
    endcase
  endfunction : refresh_ticks

  // Codes 6 and 7 are illegal and fall back to the longest timeout
  function automatic logic [TICK_W-1:0] timer_ticks(input logic [2:0] sel);
    case (sel)
      3'h1: timer_ticks = ticks(TMO1_NS);
      3'h2: timer_ticks = ticks(TMO2_NS);
      3'h3: timer_ticks = ticks(TMO3_NS);
      3'h4: timer_ticks = ticks(TMO4_NS);
      3'h5: timer_ticks = ticks(TMO5_NS);
      default: timer_ticks = ticks(TMO0_NS);
    endcase
  endfunction : timer_ticks
endpackage : bpsw_pkg

// file: core/bpsw_tmr_if.sv
`timescale 1ns/1ps
`default_nettype none
interface bpsw_tmr_if;
  logic tick;
  logic run;
  logic [2:0] sel;
  logic expire;
  modport ctl(output tick, output run, output sel, input expire);
  modport tmr(input tick, input run, input sel, output expire);
endinterface : bpsw_tmr_if
`default_nettype wire

// file: core/bpsw_ref_timer.sv
`timescale 1ns/1ps
`default_nettype none
module bpsw_ref_timer (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  bpsw_tmr_if.tmr tmr
);
  logic [bpsw_pkg::TICK_W-1:0] cnt_q;
  logic [bpsw_pkg::TICK_W-1:0] last;
  logic exp_q;

  assign last = bpsw_pkg::timer_ticks(tmr.sel) - 14'h1;

  // Tick counter; stopped timer restarts from zero
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q <= '0;
    end else if (!tmr.run) begin
      cnt_q <= '0;
    end else if (tmr.tick) begin
      // Compare with >= so a shorter period chosen mid-count still wraps
      cnt_q <= (cnt_q >= last) ? '0 : cnt_q + 14'h1;
    end
  end

  // One-cycle expiry pulse at the end of each period
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      exp_q <= 1'b0;
    end else begin
      exp_q <= tmr.run && tmr.tick && (cnt_q >= last);
    end
  end

  assign tmr.expire = exp_q;

  AST_TMR_WRAP: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    exp_q |-> cnt_q == '0 && !$past(exp_q))
    else $error("timer expiry without counter wrap");
endmodule : bpsw_ref_timer
`default_nettype wire

// file: core/bpsw_power_switch.sv
// Function
// - Flag domain reset so software sees lost domain state.
// - Flag a high-to-low edge on the wakeup pin.
// - Two independent reference timers, each flags its own expiry.
// - Regulator-ready flag reads set once regulator enabled and ready.
// - Per-source interrupt enables, plus one enable-all setting.
// - Per-source wakeup enables, plus one enable-all setting.
// - Low-power refresh at 7.8125, 15.625, 31.25 or 62.5 ms.
// - Timer period choice: 1 s down to 31.25 ms, six values.
// - Software turns slow oscillator on and off and reads its state.
// - Separate gate for the oscillator output to other modules.
// - Oscillator lock freezes oscillator settings until domain reset.
// - Output gate stays writable after the oscillator lock.
// - Readable bandgap enable, frozen by the RAM settings lock.
// - Refresh mode enable, also frozen by the RAM settings lock.
// - RAM settings lock rejects regulator updates until domain reset.
// - Software command moves RAM supply back to core supply.
// - Setting keeps SRAM array retained from core supply.
// - Isolation enable isolates SRAM, else SRAM follows power modes.
// - Timers run only with bandgap on, ticking from the oscillator.
// - Write-one clears flags; regulator-ready flag is not cleared.
// - Interrupt/wakeup lock freezes both enables until domain reset.
//
// Design decisions made here: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module bpsw_power_switch #(
  parameter int P_OSC_DIV = bpsw_pkg::OSC_DIV_CYC
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic [4:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_wake_pin,
  output logic o_osc_en,
  output logic o_osc_clk_en,
  output logic o_bg_en,
  output logic o_bg_refresh,
  output logic o_ram_reg_en,
  output logic o_sram_on_batt,
  output logic o_sram_retain,
  output logic o_sram_iso,
  output logic o_irq,
  output logic o_wake
);
  localparam int NF = bpsw_pkg::NUM_FLAGS;
  localparam int TW = bpsw_pkg::TICK_W;

  if (P_OSC_DIV < 2 || P_OSC_DIV > 4096) begin : g_bad_div
    $error("P_OSC_DIV out of range");
  end

  logic ack_q;
  logic [31:0] rdata_q;
  logic [31:0] rd_mux;
  logic wr;
  logic [7:0] wd;
  logic [11:0] div_q;
  logic osc_tick;
  logic osc_en_q, osc_gate_q, osc_lock_q;
  logic bg_en_q, rfr_en_q;
  logic [1:0] rfr_sel_q;
  logic [TW-1:0] rfr_cnt_q;
  logic rfr_q;
  logic [1:0] tmr_en_q;
  logic [2:0] tmr_sel_q [2];
  logic [1:0] tmr_exp;
  logic reg_en_q, batt_q, retain_q, iso_q, ram_lock_q;
  logic [4:0] rdy_cnt_q;
  logic rdy_q;
  logic wk_s1_q, wk_s2_q, wk_s3_q;
  logic wake_fall;
  logic [3:0] flag_q;
  logic [NF-1:0] status;
  logic [NF-1:0] irq_en_q, wake_en_q;
  logic iw_lock_q;

  // One wait state: request taken at the edge where waitrequest is low
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_q;
  assign wr = i_avs_write & ack_q & i_avs_byteenable[0];
  assign wd = i_avs_writedata[7:0];
  assign o_avs_readdata = rdata_q;

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (i_avs_read | i_avs_write) & ~ack_q;
    end
  end

  // Read data registered in the waiting cycle, held until next read
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_q <= '0;
    end else if (i_avs_read && !ack_q) begin
      rdata_q <= rd_mux;
    end
  end

  // Register readback; unmapped offsets read zero
  always_comb begin
    rd_mux = '0;
    unique case (i_avs_address)
      bpsw_pkg::REG_OSC: begin
        rd_mux[bpsw_pkg::OSC_EN_BIT] = osc_en_q;
        rd_mux[bpsw_pkg::OSC_GATE_BIT] = osc_gate_q;
        rd_mux[bpsw_pkg::OSC_LOCK_BIT] = osc_lock_q;
        rd_mux[bpsw_pkg::OSC_RUN_BIT] = osc_en_q;
      end
      bpsw_pkg::REG_BG: begin
        rd_mux[bpsw_pkg::BG_EN_BIT] = bg_en_q;
        rd_mux[bpsw_pkg::BG_RFR_EN_BIT] = rfr_en_q;
        rd_mux[bpsw_pkg::BG_RFR_SEL_LSB +: 2] = rfr_sel_q;
        rd_mux[bpsw_pkg::BG_STATE_BIT] = bg_en_q;
      end
      bpsw_pkg::REG_TMR: begin
        rd_mux[bpsw_pkg::TMR_EN_LSB +: 2] = tmr_en_q;
        rd_mux[bpsw_pkg::TMR0_SEL_LSB +: 3] = tmr_sel_q[0];
        rd_mux[bpsw_pkg::TMR1_SEL_LSB +: 3] = tmr_sel_q[1];
      end
      bpsw_pkg::REG_RAM: begin
        rd_mux[bpsw_pkg::RAM_REG_EN_BIT] = reg_en_q;
        rd_mux[bpsw_pkg::RAM_BATT_BIT] = batt_q;
        rd_mux[bpsw_pkg::RAM_RETAIN_BIT] = retain_q;
        rd_mux[bpsw_pkg::RAM_ISO_BIT] = iso_q;
        rd_mux[bpsw_pkg::RAM_LOCK_BIT] = ram_lock_q;
      end
      bpsw_pkg::REG_STAT: rd_mux[NF-1:0] = status;
      bpsw_pkg::REG_IRQ_EN: rd_mux[NF-1:0] = irq_en_q;
      bpsw_pkg::REG_WAKE_EN: rd_mux[NF-1:0] = wake_en_q;
      bpsw_pkg::REG_IW_LOCK: rd_mux[0] = iw_lock_q;
      default: rd_mux = '0;
    endcase
  end

  // Slow oscillator model: tick enable every P_OSC_DIV clocks while on
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_q <= '0;
    end else if (!osc_en_q || osc_tick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 12'h1;
    end
  end
  assign osc_tick = osc_en_q && (div_q == 12'(P_OSC_DIV - 1));

  // Oscillator settings; the lock leaves the output gate writable
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      osc_en_q <= 1'b0;
      osc_gate_q <= 1'b0;
      osc_lock_q <= 1'b0;
    end else if (wr && i_avs_address == bpsw_pkg::REG_OSC) begin
      if (!osc_lock_q) begin
        osc_en_q <= wd[bpsw_pkg::OSC_EN_BIT];
        osc_lock_q <= wd[bpsw_pkg::OSC_LOCK_BIT];
      end
      osc_gate_q <= wd[bpsw_pkg::OSC_GATE_BIT];
    end
  end

  // Bandgap enable and refresh mode, frozen by the RAM settings lock
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bg_en_q <= 1'b0;
      rfr_en_q <= 1'b0;
      rfr_sel_q <= '0;
    end else if (wr && i_avs_address == bpsw_pkg::REG_BG && !ram_lock_q) begin
      // Enable refused while the oscillator is off
      bg_en_q <= wd[bpsw_pkg::BG_EN_BIT] & osc_en_q;
      rfr_en_q <= wd[bpsw_pkg::BG_RFR_EN_BIT];
      rfr_sel_q <= wd[bpsw_pkg::BG_RFR_SEL_LSB +: 2];
    end
  end

  // Refresh strobe at the selected interval in refresh mode
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rfr_cnt_q <= '0;
      rfr_q <= 1'b0;
    end else if (!(bg_en_q && rfr_en_q)) begin
      rfr_cnt_q <= '0;
      rfr_q <= 1'b0;
    end else begin
      rfr_q <= 1'b0;
      if (osc_tick) begin
        if (rfr_cnt_q >= bpsw_pkg::refresh_ticks(rfr_sel_q) - 14'h1) begin
          rfr_cnt_q <= '0;
          rfr_q <= 1'b1;
        end else begin
          rfr_cnt_q <= rfr_cnt_q + 14'h1;
        end
      end
    end
  end

  // Timer enables and period selects
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tmr_en_q <= '0;
      tmr_sel_q[0] <= '0;
      tmr_sel_q[1] <= '0;
    end else if (wr && i_avs_address == bpsw_pkg::REG_TMR) begin
      tmr_en_q <= wd[bpsw_pkg::TMR_EN_LSB +: 2];
      tmr_sel_q[0] <= wd[bpsw_pkg::TMR0_SEL_LSB +: 3];
      tmr_sel_q[1] <= wd[bpsw_pkg::TMR1_SEL_LSB +: 3];
    end
  end

  // Two identical timers, run only with bandgap and oscillator on
  for (genvar g = 0; g < 2; g++) begin : g_tmr
    bpsw_tmr_if u_if ();
    assign u_if.tick = osc_tick;
    assign u_if.run = tmr_en_q[g] & bg_en_q & osc_en_q;
    assign u_if.sel = tmr_sel_q[g];
    assign tmr_exp[g] = u_if.expire;
    bpsw_ref_timer u_tmr (
      .i_clk_sys(i_clk_sys),
      .i_rst_n(i_rst_n),
      .tmr(u_if.tmr)
    );
  end

  // RAM supply settings; switch back to core supply is never locked
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      reg_en_q <= 1'b0;
      batt_q <= 1'b0;
      retain_q <= 1'b0;
      iso_q <= 1'b0;
      ram_lock_q <= 1'b0;
    end else if (wr && i_avs_address == bpsw_pkg::REG_RAM) begin
      if (!ram_lock_q) begin
        // Regulator needs oscillator and bandgap already on
        reg_en_q <= wd[bpsw_pkg::RAM_REG_EN_BIT] & osc_en_q & bg_en_q;
        retain_q <= wd[bpsw_pkg::RAM_RETAIN_BIT];
        ram_lock_q <= wd[bpsw_pkg::RAM_LOCK_BIT];
      end
      batt_q <= wd[bpsw_pkg::RAM_BATT_BIT] & osc_en_q;
      iso_q <= wd[bpsw_pkg::RAM_ISO_BIT];
    end
  end

  // Regulator settling, counted in oscillator ticks
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdy_cnt_q <= '0;
      rdy_q <= 1'b0;
    end else if (!reg_en_q) begin
      rdy_cnt_q <= '0;
      rdy_q <= 1'b0;
    end else if (osc_tick && !rdy_q) begin
      rdy_cnt_q <= rdy_cnt_q + 5'h1;
      rdy_q <= rdy_cnt_q == 5'(bpsw_pkg::REG_READY_TICKS - 1);
    end
  end

  // Wake pin synchroniser and falling-edge detect on synced stages
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wk_s1_q <= 1'b1;
      wk_s2_q <= 1'b1;
      wk_s3_q <= 1'b1;
    end else begin
      wk_s1_q <= i_wake_pin;
      wk_s2_q <= wk_s1_q;
      wk_s3_q <= wk_s2_q;
    end
  end
  assign wake_fall = wk_s3_q & ~wk_s2_q;

  // Sticky flags; a set in the clearing cycle wins over the clear
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flag_q <= bpsw_pkg::FLAG_RESET;
    end else begin
      flag_q <= (flag_q & ~((wr && i_avs_address == bpsw_pkg::REG_STAT) ?
                wd[3:0] : 4'h0))
                | {tmr_exp[1], tmr_exp[0], wake_fall, 1'b0};
    end
  end
  assign status = {rdy_q, flag_q};

  // Enables with enable-all bit; frozen by the interrupt/wakeup lock
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_en_q <= '0;
      wake_en_q <= '0;
      iw_lock_q <= 1'b0;
    end else if (wr && !iw_lock_q) begin
      if (i_avs_address == bpsw_pkg::REG_IRQ_EN) begin
        irq_en_q <= wd[NF-1:0] | {NF{wd[bpsw_pkg::ALL_EN_BIT]}};
      end
      if (i_avs_address == bpsw_pkg::REG_WAKE_EN) begin
        wake_en_q <= wd[NF-1:0] | {NF{wd[bpsw_pkg::ALL_EN_BIT]}};
      end
      if (i_avs_address == bpsw_pkg::REG_IW_LOCK) begin
        iw_lock_q <= wd[0];
      end
    end
  end

  // Outputs, all from flops or gates of flops
  assign o_irq = |(status & irq_en_q);
  assign o_wake = |(status & wake_en_q);
  assign o_osc_en = osc_en_q;
  assign o_osc_clk_en = osc_tick & osc_gate_q;
  assign o_bg_en = bg_en_q;
  assign o_bg_refresh = rfr_q;
  assign o_ram_reg_en = reg_en_q;
  assign o_sram_on_batt = batt_q;
  assign o_sram_retain = retain_q;
  assign o_sram_iso = iso_q;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  AST_WAKE_EDGE: assert property (wake_fall |=> flag_q[bpsw_pkg::FLG_WAKE])
    else $error("wake edge not flagged");
  AST_TMR1_FLAG: assert property (tmr_exp[1] |=> status[bpsw_pkg::FLG_TMR1])
    else $error("timer1 expiry not flagged");
  AST_RDY_EN: assert property (rdy_q |-> reg_en_q && $past(bg_en_q))
    else $error("ready without regulator enabled");
  AST_IRQ_OUT: assert property (status[bpsw_pkg::FLG_TMR0] && irq_en_q[bpsw_pkg::FLG_TMR0] |-> o_irq)
    else $error("enabled flag gives no interrupt");
  AST_WAKE_OUT: assert property (!(|(status & wake_en_q)) |-> !o_wake)
    else $error("wakeup without enabled flag");
  AST_OSC_LOCK: assert property (osc_lock_q |=> $stable(osc_en_q) && osc_lock_q)
    else $error("oscillator changed under lock");
  AST_GATE: assert property (o_osc_clk_en |-> osc_gate_q && osc_en_q && div_q != '0)
    else $error("gated clock escaped");
  AST_RAM_LOCK: assert property (ram_lock_q |=> $stable(bg_en_q) && $stable(reg_en_q) && $stable(rfr_en_q))
    else $error("RAM settings changed under lock");
  AST_IW_LOCK: assert property (iw_lock_q |=> $stable(irq_en_q) && $stable(wake_en_q))
    else $error("enables changed under lock");
  AST_BG_OSC: assert property ($rose(bg_en_q) |-> $past(osc_en_q))
    else $error("bandgap enabled with oscillator off");
  AST_RFR: assert property (o_bg_refresh |-> $past(osc_tick) && $past(rfr_en_q))
    else $error("refresh outside refresh mode");
  AST_BUS_WAIT: assert property (i_avs_read && !ack_q |=> !o_avs_waitrequest || !i_avs_read)
    else $error("bus answer late");

  COV_WAKE_IRQ: cover property (wake_fall ##1 o_irq);
  COV_TMR0: cover property (tmr_exp[0]);
  COV_RDY: cover property ($rose(rdy_q));
  COV_REFRESH: cover property (o_bg_refresh);
endmodule : bpsw_power_switch
`default_nettype wire

// file: bench/bpsw_power_switch_tb.sv
`timescale 1ns/1ps
`default_nettype none
module bpsw_power_switch_tb;
  localparam int DIV = 4;
  localparam int LIMIT = 60000;
  logic i_clk_sys = 1'b0;
  logic i_rst_n = 1'b0;
  logic [4:0] adr = 5'h00;
  logic rd_q = 1'b0;
  logic wr_q = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic wake_pin = 1'b1;
  logic [31:0] rdat;
  logic waitreq, osc_en, osc_clk_en, bg_en, bg_rfr, reg_en;
  logic on_batt, retain, iso, irq, wake;
  int failures = 0;
  int total_checks = 0;
  int cyc = 0;
  logic [31:0] r;
  int n, t, t0, t1;
  int rf[4] = '{bpsw_pkg::RFR0_NS, bpsw_pkg::RFR1_NS, bpsw_pkg::RFR2_NS,
                bpsw_pkg::RFR3_NS};

  bpsw_power_switch #(.P_OSC_DIV(DIV)) dut_u (
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_avs_address(adr),
    .i_avs_read(rd_q), .i_avs_write(wr_q), .i_avs_writedata(wdat),
    .i_avs_byteenable(4'h1), .o_avs_readdata(rdat),
    .o_avs_waitrequest(waitreq), .i_wake_pin(wake_pin),
    .o_osc_en(osc_en), .o_osc_clk_en(osc_clk_en), .o_bg_en(bg_en),
    .o_bg_refresh(bg_rfr), .o_ram_reg_en(reg_en),
    .o_sram_on_batt(on_batt), .o_sram_retain(retain), .o_sram_iso(iso),
    .o_irq(irq), .o_wake(wake)
  );

  // Free-running system clock
  always #12.5 i_clk_sys = ~i_clk_sys;

  // Hang guard, counts as a mismatch
  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == LIMIT) begin
      failures++;
      close_out();
    end
  end

  task automatic close_out();
    $display("Checks %0d, mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : close_out

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One Avalon access; request held until waitrequest is low at an edge
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int k;
    k = 0;
    @(posedge i_clk_sys);
    adr <= a;
    rd_q <= !w;
    wr_q <= w;
    wdat <= d;
    do begin
      @(posedge i_clk_sys);
      k++;
    end while (waitreq !== 1'b0 && k < 100);
    if (k >= 100) failures++;
    q = rdat;
    rd_q <= 1'b0;
    wr_q <= 1'b0;
    // Idle half cycle so callers see outputs launched by this write
    @(negedge i_clk_sys);
  endtask : bus

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask : wr

  task automatic rd(input logic [4:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0, q);
  endtask : rd

  // Oscillator output pulses seen over 40 clocks
  task automatic pulses(output int c);
    c = 0;
    repeat (40) begin
      @(negedge i_clk_sys);
      if (osc_clk_en === 1'b1) c++;
    end
  endtask : pulses

  // Clocks between two refresh pulses
  task automatic gap(output int c);
    int w;
    w = 0;
    c = 0;
    @(negedge i_clk_sys);
    while (bg_rfr !== 1'b1 && w < 20000) begin
      @(negedge i_clk_sys);
      w++;
    end
    do begin
      @(negedge i_clk_sys);
      c++;
    end while (bg_rfr !== 1'b1 && c < 20000);
  endtask : gap

  task automatic do_reset();
    @(posedge i_clk_sys);
    i_rst_n <= 1'b0;
    repeat (6) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
  endtask : do_reset

  initial begin
    do_reset();
    rd(bpsw_pkg::REG_STAT, r);
    check(r, 32'h01);
    rd(5'h02, r);
    check(r, 32'h0);
    // Bandgap refused while the oscillator is still off
    wr(bpsw_pkg::REG_BG, 32'h01);
    rd(bpsw_pkg::REG_BG, r);
    check(r, 32'h0);
    wr(bpsw_pkg::REG_OSC, 32'h03);
    rd(bpsw_pkg::REG_OSC, r);
    check(r, 32'h0b);
    pulses(n);
    check(32'(n), 32'(40 / DIV));
    wr(bpsw_pkg::REG_OSC, 32'h05);
    pulses(n);
    check(32'(n), 32'h0);
    // Lock holds enable, gate stays free
    wr(bpsw_pkg::REG_OSC, 32'h02);
    rd(bpsw_pkg::REG_OSC, r);
    check(r, 32'h0f);
    check({31'h0, osc_en}, 32'h1);
    // Every refresh interval, measured between pulses
    for (int s = 0; s < 4; s++) begin
      wr(bpsw_pkg::REG_BG, 32'h03 | 32'(s << 2));
      gap(n);
      check(32'(n), 32'(rf[s] / bpsw_pkg::OSC_PERIOD_NS * DIV));
    end
    rd(bpsw_pkg::REG_BG, r);
    check(r, 32'h1f);
    // Both timers race; irq shows timer0, wake shows timer1
    wr(bpsw_pkg::REG_BG, 32'h01);
    wr(bpsw_pkg::REG_STAT, 32'h0f);
    wr(bpsw_pkg::REG_IRQ_EN, 32'h04);
    wr(bpsw_pkg::REG_WAKE_EN, 32'h08);
    wr(bpsw_pkg::REG_TMR, 32'h97);
    t = 0;
    t0 = 0;
    t1 = 0;
    while (t1 == 0 && t < 6000) begin
      @(negedge i_clk_sys);
      t++;
      if (irq === 1'b1 && t0 == 0) t0 = t;
      if (wake === 1'b1 && t1 == 0) t1 = t;
    end
    check(32'(t0 > 1990 && t0 < 2012), 32'h1);
    check(32'(t1 > 3990 && t1 < 4012), 32'h1);
    // Timers hold still with the bandgap off
    wr(bpsw_pkg::REG_BG, 32'h00);
    wr(bpsw_pkg::REG_STAT, 32'h0c);
    repeat (4500) @(negedge i_clk_sys);
    rd(bpsw_pkg::REG_STAT, r);
    check(r & 32'h0c, 32'h0);
    check({31'h0, irq}, 32'h0);
    wr(bpsw_pkg::REG_BG, 32'h01);
    // Enable-all bits, then the wakeup pin edge
    wr(bpsw_pkg::REG_IRQ_EN, 32'h20);
    rd(bpsw_pkg::REG_IRQ_EN, r);
    check(r, 32'h1f);
    wr(bpsw_pkg::REG_WAKE_EN, 32'h20);
    rd(bpsw_pkg::REG_WAKE_EN, r);
    check(r, 32'h1f);
    @(posedge i_clk_sys);
    wake_pin <= 1'b0;
    repeat (10) @(negedge i_clk_sys);
    rd(bpsw_pkg::REG_STAT, r);
    check(r & 32'h02, 32'h02);
    check({30'h0, irq, wake}, 32'h3);
    wr(bpsw_pkg::REG_IW_LOCK, 32'h01);
    wr(bpsw_pkg::REG_IRQ_EN, 32'h00);
    rd(bpsw_pkg::REG_IRQ_EN, r);
    check(r, 32'h1f);
    // Regulator ready cannot be cleared by software
    wr(bpsw_pkg::REG_RAM, 32'h01);
    // Poll for ready, giving up after a bounded number of reads
    n = 0;
    do begin
      rd(bpsw_pkg::REG_STAT, r);
      n++;
    end while (r[4] !== 1'b1 && n < 50);
    check({31'h0, r[4]}, 32'h1);
    wr(bpsw_pkg::REG_STAT, 32'h1f);
    rd(bpsw_pkg::REG_STAT, r);
    check(r & 32'h10, 32'h10);
    wr(bpsw_pkg::REG_RAM, 32'h0f);
    check({28'h0, reg_en, on_batt, retain, iso}, 32'hf);
    wr(bpsw_pkg::REG_RAM, 32'h11);
    check({28'h0, reg_en, on_batt, retain, iso}, 32'h8);
    // Settings lock freezes regulator and bandgap
    wr(bpsw_pkg::REG_RAM, 32'h00);
    wr(bpsw_pkg::REG_BG, 32'h00);
    rd(bpsw_pkg::REG_RAM, r);
    check(r, 32'h11);
    rd(bpsw_pkg::REG_BG, r);
    check(r, 32'h11);
    check({31'h0, bg_en}, 32'h1);
    // A second domain reset flags again and releases the locks
    do_reset();
    rd(bpsw_pkg::REG_STAT, r);
    check(r & 32'h01, 32'h01);
    wr(bpsw_pkg::REG_OSC, 32'h01);
    rd(bpsw_pkg::REG_OSC, r);
    check(r, 32'h09);
    close_out();
  end
endmodule : bpsw_power_switch_tb
`default_nettype wire
